// ==== epr_consts.vh ====
// Constants for the evaporator pump relay controller.
// Assumes a 40 MHz mclk and a 1 ms enable derived inside the controller.
`ifndef EPR_CONSTS_VH
`define EPR_CONSTS_VH

// Clock rate and the millisecond tick divider.
`define EPR_CLK_HZ          40000000
`define EPR_MS_DIV          40000
`define EPR_MS_DIV_W        16

// Timer widths: millisecond counter and off-delay in minutes.
`define EPR_MS_W            22
`define EPR_DELAY_MIN_W     5

// Flow-proving limits in seconds and off-delay cap in minutes, converted to milliseconds.
`define EPR_FLOW_NORM_S     1200
`define EPR_FLOW_OVR_S      255
`define EPR_MS_PER_S        1000
`define EPR_MS_PER_MIN      60000
`define EPR_DELAY_MAX_MIN   30

// Chiller mode codes.
`define EPR_MODE_W          10
`define EPR_MODE_AUTO       10'h3ff
`define EPR_MODE_RESET      10'h058
`define EPR_MODE_STOP       10'h000
`define EPR_MODE_EXT_STOP   10'h064
`define EPR_MODE_DISP_STOP  10'h258
`define EPR_MODE_BAS_STOP   10'h12c
`define EPR_MODE_LOW_AMB    10'h0c8
`define EPR_MODE_ICE_DONE   10'h065

`endif

// ==== epr_pump_relay_ctrl.v ====
// Evaporator pump relay controller: relay, off-delay and flow supervision.
// Assumes all inputs are synchronous to mclk and mode codes are stable.
`timescale 1ns/1ps
`include "epr_consts.vh"

module epr_pump_relay_ctrl (
  input  wire                          mclk,
  input  wire                          rst,
  input  wire [`EPR_MODE_W-1:0]        chiller_mode,
  input  wire [`EPR_DELAY_MIN_W-1:0]   off_delay_min,
  input  wire                          override_pump_on,
  input  wire                          evap_flow,
  input  wire                          diag_other,
  input  wire                          diag_low_water_temp,
  input  wire                          diag_lwt_sensor,
  input  wire                          diag_contactor_fail,
  output reg                           evap_pump_relay,
  output reg                           diag_flow_timeout,
  output reg                           diag_flow_lost,
  output reg                           stop_mode_active
);

  // Controller states, one-hot.
  localparam [3:0] ST_OFF   = 4'h1;
  localparam [3:0] ST_PROVE = 4'h2;
  localparam [3:0] ST_RUN   = 4'h4;
  localparam [3:0] ST_DELAY = 4'h8;

  // Timer constants at full integer width, cut to the timer width below.
  localparam [31:0] DELAY_CAP_FULL = `EPR_DELAY_MAX_MIN;
  localparam [31:0] PROVE_NORM_MS  = `EPR_FLOW_NORM_S * `EPR_MS_PER_S;
  localparam [31:0] PROVE_OVR_MS   = `EPR_FLOW_OVR_S * `EPR_MS_PER_S;
  localparam [`EPR_DELAY_MIN_W-1:0] DELAY_CAP =
    DELAY_CAP_FULL[`EPR_DELAY_MIN_W-1:0];

  reg [3:0]                   state;
  reg [3:0]                   next_state;
  reg [`EPR_MS_DIV_W-1:0]     div_cnt;
  reg                         ms_tick;
  reg [`EPR_MS_W-1:0]         ms_cnt;
  reg [`EPR_MS_W-1:0]         prove_limit;
  reg                         was_override;
  reg                         next_relay;
  reg                         clr_cnt;
  wire                        auto_mode;
  wire                        keep_diag;
  wire                        open_diag;
  wire                        hard_diag;
  wire                        any_diag;
  wire [31:0]                 delay_full;
  wire [`EPR_MS_W-1:0]        delay_ms;
  wire [`EPR_DELAY_MIN_W-1:0] delay_clip;

  // Auto mode, or an override safety, calls for the pump.
  assign auto_mode = (chiller_mode == `EPR_MODE_AUTO) | override_pump_on;

  // Diagnostics that leave the relay closed when they stand alone.
  assign keep_diag = diag_contactor_fail
                   | (diag_low_water_temp & ~diag_lwt_sensor);
  // Diagnostics that always open; a sensor fault also voids the low
  // water temperature exemption.
  assign hard_diag = diag_other | diag_lwt_sensor;
  // Any diagnostic opens the relay at once unless only exempt ones
  // stand. Heater supply and thermostat have no input here.
  assign any_diag  = diag_other | diag_lwt_sensor
                   | diag_low_water_temp | diag_contactor_fail;
  assign open_diag = any_diag & (hard_diag | ~keep_diag);

  // Off-delay clipped to thirty minutes, held in milliseconds.
  assign delay_clip = (off_delay_min > DELAY_CAP) ?
                      DELAY_CAP : off_delay_min;
  assign delay_full = delay_clip * `EPR_MS_PER_MIN;
  assign delay_ms   = delay_full[`EPR_MS_W-1:0];

  // Millisecond enable divider.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt <= {`EPR_MS_DIV_W{1'b0}};
      ms_tick <= 1'b0;
    end else if (div_cnt == `EPR_MS_DIV - 1) begin
      div_cnt <= {`EPR_MS_DIV_W{1'b0}};
      ms_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      ms_tick <= 1'b0;
    end
  end

  // Next state and relay; the relay output is registered.
  always @* begin
    next_state = state;
    next_relay = 1'b0;
    clr_cnt    = 1'b0;
    case (state)
      ST_OFF: begin
        // While a flow timeout stands the relay stays open unless flow is seen,
        // for example from a pump run by another party.
        if (auto_mode && !open_diag &&
            (!diag_flow_timeout || evap_flow)) begin
          next_state = ST_PROVE;
          next_relay = 1'b1;
          clr_cnt    = 1'b1;
        end
      end
      ST_PROVE: begin
        next_relay = 1'b1;
        if (open_diag) begin
          next_state = ST_OFF;
          next_relay = 1'b0;
        end else if (!auto_mode) begin
          next_state = ST_DELAY;
          clr_cnt    = 1'b1;
        end else if (evap_flow) begin
          next_state = ST_RUN;
        end else if (ms_cnt >= prove_limit) begin
          next_state = ST_OFF;
          next_relay = 1'b0;
        end
      end
      ST_RUN: begin
        next_relay = 1'b1;
        if (open_diag) begin
          next_state = ST_OFF;
          next_relay = 1'b0;
        end else if (!auto_mode) begin
          next_state = ST_DELAY;
          clr_cnt    = 1'b1;
        end
      end
      ST_DELAY: begin
        next_relay = 1'b1;
        if (open_diag) begin
          next_state = ST_OFF;
          next_relay = 1'b0;
        end else if (auto_mode) begin
          next_state = evap_flow ? ST_RUN : ST_PROVE;
          clr_cnt    = 1'b1;
        end else if (ms_cnt >= delay_ms) begin
          next_state = ST_OFF;
          next_relay = 1'b0;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // State, relay and millisecond timer registers.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state           <= ST_OFF;
      evap_pump_relay <= 1'b0;
      ms_cnt          <= {`EPR_MS_W{1'b0}};
      was_override    <= 1'b0;
    end else begin
      state           <= next_state;
      evap_pump_relay <= next_relay;
      if (clr_cnt) begin
        ms_cnt       <= {`EPR_MS_W{1'b0}};
        was_override <= override_pump_on;
      end else if (ms_tick && (ms_cnt != {`EPR_MS_W{1'b1}})) begin
        ms_cnt <= ms_cnt + 1'b1;
      end
    end
  end

  // Proving limit follows the kind of start.
  always @* begin
    if (was_override) begin
      prove_limit = PROVE_OVR_MS[`EPR_MS_W-1:0];
    end else begin
      prove_limit = PROVE_NORM_MS[`EPR_MS_W-1:0];
    end
  end

  // Flow diagnostics; both clear on their own when flow returns.  A
  // withdrawn run request also clears the timeout so a new start retries.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      diag_flow_timeout <= 1'b0;
      diag_flow_lost    <= 1'b0;
    end else begin
      if (evap_flow) begin
        diag_flow_timeout <= 1'b0;
      end else if (state == ST_PROVE && next_state == ST_OFF &&
                   !open_diag) begin
        diag_flow_timeout <= 1'b1;
      end else if (!auto_mode) begin
        diag_flow_timeout <= 1'b0;
      end
      diag_flow_lost <= (state == ST_RUN) && auto_mode &&
                        !evap_flow;
    end
  end

  // Stop-mode indication for the listed pump-stopped codes.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      stop_mode_active <= 1'b0;
    end else begin
      case (chiller_mode)
        `EPR_MODE_RESET, `EPR_MODE_STOP, `EPR_MODE_EXT_STOP,
        `EPR_MODE_DISP_STOP, `EPR_MODE_BAS_STOP, `EPR_MODE_LOW_AMB,
        `EPR_MODE_ICE_DONE: stop_mode_active <= 1'b1;
        default: stop_mode_active <= 1'b0;
      endcase
    end
  end

endmodule // epr_pump_relay_ctrl

// ==== epr_chk.sv ====
// Checker watching the pump relay controller ports.
// Assumes one clock domain and an active-high reset.
`timescale 1ns/1ps
`include "epr_consts.vh"
module epr_chk (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [9:0] chiller_mode,
  input wire logic [4:0] off_delay_min,
  input wire logic       override_pump_on,
  input wire logic       evap_flow,
  input wire logic       diag_other,
  input wire logic       diag_low_water_temp,
  input wire logic       diag_lwt_sensor,
  input wire logic       diag_contactor_fail,
  input wire logic       evap_pump_relay,
  input wire logic       diag_flow_timeout,
  input wire logic       diag_flow_lost,
  input wire logic       stop_mode_active
);
  // Run request and diagnostics that must open the relay.
  wire run = (chiller_mode == `EPR_MODE_AUTO) || override_pump_on;
  wire opn = diag_other || diag_lwt_sensor;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_flowing;
    evap_pump_relay && evap_flow && run && !opn;
  endsequence
  sequence s_drop;
    !evap_flow && run && !opn;
  endsequence
  property p_lost; s_flowing ##1 s_flowing ##1 s_drop
    |=> diag_flow_lost && evap_pump_relay; endproperty
  property p_open; opn [*2] |=> !evap_pump_relay; endproperty
  property p_close; $rose(run) && !opn && !diag_flow_timeout
    |-> ##[1:2] evap_pump_relay; endproperty
  property p_off0; (!run && off_delay_min == 5'h00) [*3]
    |=> !evap_pump_relay; endproperty
  property p_code; chiller_mode inside {`EPR_MODE_RESET, `EPR_MODE_STOP,
    `EPR_MODE_EXT_STOP, `EPR_MODE_DISP_STOP, `EPR_MODE_BAS_STOP,
    `EPR_MODE_LOW_AMB, `EPR_MODE_ICE_DONE} |=> stop_mode_active; endproperty
  property p_keep; s_flowing |=> evap_pump_relay; endproperty
  property p_toclr; diag_flow_timeout && evap_flow
    |-> ##[1:2] !diag_flow_timeout; endproperty
  property p_hold; $fell(run) && evap_pump_relay && !opn &&
    off_delay_min != 5'h00 |=> evap_pump_relay [*4]; endproperty
  a_lost: assert property (p_lost) else $error("flow lost not flagged");
  a_open: assert property (p_open) else $error("relay kept on diag");
  a_close: assert property (p_close) else $error("relay late");
  a_off0: assert property (p_off0) else $error("zero delay held");
  a_code: assert property (p_code) else $error("stop code missed");
  a_keep: assert property (p_keep) else $error("relay dropped");
  a_toclr: assert property (p_toclr) else $error("timeout stuck");
  a_hold: assert property (p_hold) else $error("delay cut short");
endmodule // epr_chk
bind epr_pump_relay_ctrl epr_chk epr_chk_i (.*);

// ==== epr_pump_model.sv ====
// Pump contactor and flow switch model.
// Assumes flow proves two cycles after the relay closes.
`timescale 1ns/1ps
module epr_pump_model (
  input  wire mclk,
  input  wire evap_pump_relay,
  input  wire pump_fail,
  output reg  evap_flow = 1'b0
);
  reg run = 1'b0;
  // Flow follows the contactor with lag, and dies on a pump fault.
  always @(posedge mclk) begin
    run <= evap_pump_relay;
    evap_flow <= run && !pump_fail;
  end
endmodule // epr_pump_model

// ==== tb_top.sv ====
// Self-checking bench for the pump relay controller.
// Assumes the pump model supplies flow from the relay.
`timescale 1ns/1ps
`include "epr_consts.vh"
module tb_top;
  reg       mclk = 0, rst = 1, ovr = 0, fail = 0;
  reg [9:0] mode = `EPR_MODE_STOP;
  reg [4:0] dly = 5'h00;
  reg [3:0] dg = 4'h0;
  wire      relay, flow, f_to, f_lost, stp;
  integer   miscompares = 0, checks = 0, k;
  logic [9:0] c [7] = '{`EPR_MODE_RESET, `EPR_MODE_STOP, `EPR_MODE_EXT_STOP,
    `EPR_MODE_DISP_STOP, `EPR_MODE_BAS_STOP, `EPR_MODE_LOW_AMB,
    `EPR_MODE_ICE_DONE};
  epr_pump_relay_ctrl epr_pump_relay_ctrl_i (.mclk(mclk), .rst(rst),
    .chiller_mode(mode), .off_delay_min(dly), .override_pump_on(ovr),
    .evap_flow(flow), .diag_other(dg[3]), .diag_lwt_sensor(dg[2]),
    .diag_low_water_temp(dg[1]), .diag_contactor_fail(dg[0]),
    .evap_pump_relay(relay), .diag_flow_timeout(f_to),
    .diag_flow_lost(f_lost), .stop_mode_active(stp));
  epr_pump_model epr_pump_model_i (.mclk(mclk), .evap_pump_relay(relay),
    .pump_fail(fail), .evap_flow(flow));
  // Clock at 40 MHz.
  always #12.5 mclk = ~mclk;
  task chk(input logic got, input logic exp);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task t_codes;
    for (k = 0; k < 7; k++) begin
      mode = c[k];
      cyc(2);
      chk(stp, 1'b1);
      chk(relay, 1'b0);
    end
  endtask
  task t_run;
    mode = `EPR_MODE_AUTO;
    cyc(1);
    chk(relay, 1'b1);
    cyc(4);
    chk(stp, 1'b0);
    chk(f_to, 1'b0);
    chk(f_lost, 1'b0);
    fail = 1;
    cyc(5);
    chk(f_lost, 1'b1);
    chk(relay, 1'b1);
    fail = 0;
    cyc(5);
    chk(f_lost, 1'b0);
  endtask
  task t_diag(input [3:0] p, input logic e);
    dg = p;
    cyc(3);
    chk(relay, e);
    dg = 4'h0;
    cyc(6);
    chk(relay, 1'b1);
  endtask
  task t_delay;
    dly = 5'h01;
    mode = `EPR_MODE_STOP;
    cyc(5);
    chk(relay, 1'b1);
    mode = `EPR_MODE_AUTO;
    cyc(3);
    chk(relay, 1'b1);
    dly = 5'h00;
    mode = `EPR_MODE_STOP;
    cyc(3);
    chk(relay, 1'b0);
  endtask
  task t_ovr;
    ovr = 1;
    cyc(1);
    chk(relay, 1'b1);
    ovr = 0;
    cyc(4);
    chk(relay, 1'b0);
  endtask
  task print_verdict;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence: reset for five cycles, then each scenario.
  initial begin
    cyc(5);
    chk(relay, 1'b0);
    rst = 0;
    t_codes;
    t_run;
    t_diag(4'h2, 1'b1);
    t_diag(4'h1, 1'b1);
    t_diag(4'h6, 1'b0);
    t_diag(4'h8, 1'b0);
    t_diag(4'h4, 1'b0);
    t_diag(4'h9, 1'b0);
    t_delay;
    t_ovr;
    print_verdict;
  end
  // Watchdog cuts a hang short.
  initial begin
    #20000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule // tb_top
